// >>> rtl/lpt_defines.vh
// Register map, field positions, reset values and timing for the timer
`ifndef LPW_DEFINES_VH
`define LPW_DEFINES_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define LPW_IDX_CTRL1 32'h000800B0
`define LPW_IDX_GATE 32'h000800B1
`define LPW_IDX_RUN 32'h000800B2
`define LPW_IDX_PERIOD 32'h000800B4
`define LPW_IDX_MATCH0 32'h000800B8
`define LPW_IDX_WAKE 32'h000800BA
`define LPW_IDX_PROTECT 32'h000800BC
`define LPW_IDX_COUNT 32'h000800BE

// ****************************************************************
// Field positions
// ****************************************************************
`define LPW_PS_MSB 2
`define LPW_PS_LSB 0
`define LPW_CKSEL_BIT 4
`define LPW_MRE0_BIT 6
`define LPW_GATE_BIT 0
`define LPW_RUN_BIT 0
`define LPW_CLR_BIT 1
`define LPW_WKUP_BIT 0
`define LPW_UNLOCK_BIT 2

// ****************************************************************
// Masks and reset values
// ****************************************************************
`define LPW_CTRL1_MASK 8'h57
`define LPW_CTRL1_RST 8'h01
`define LPW_GATE_RST 1'b1
`define LPW_PERIOD_RST 16'hFFFF
`define LPW_MATCH0_RST 16'hFFFF

// ****************************************************************
// Timing
// ****************************************************************
`define LPW_SYNC_STAGES 3
`define LPW_PS_LAST_D2 5'h01
`define LPW_PS_LAST_D4 5'h03
`define LPW_PS_LAST_D8 5'h07
`define LPW_PS_LAST_D16 5'h0F
`define LPW_PS_LAST_MAX 5'h1F

`endif

// >>> rtl/lpt_timer.v
// Low-power wakeup timer with APB register slave
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`include "lpt_defines.vh"

module lpw_timer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire sub_clock,
  input wire wdt_osc_clock,
  input wire standby_mode,
  input wire sleep_count_stop_option,
  output reg low_power_timer_event,
  output reg match0_irq,
  output reg wakeup_request
);

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  // Register indices; the bus sees four times them
  function [31:0] lpw_addr;
    input [31:0] idx;
    begin
      lpw_addr = {idx[29:0], 2'b00};
    end
  endfunction

  // Codes outside 1 to 5 are prohibited and fall back to divide by 2
  function [4:0] lpw_div_last;
    input [2:0] code;
    begin
      case (code)
        3'h1: lpw_div_last = `LPW_PS_LAST_D2;
        3'h2: lpw_div_last = `LPW_PS_LAST_D4;
        3'h3: lpw_div_last = `LPW_PS_LAST_D8;
        3'h4: lpw_div_last = `LPW_PS_LAST_D16;
        3'h5: lpw_div_last = `LPW_PS_LAST_MAX;
        default: lpw_div_last = `LPW_PS_LAST_D2;
      endcase
    end
  endfunction

  reg [7:0] ctrl1_r;
  reg gate_stop_r;
  reg run_r;
  reg clr_req_r;
  reg [15:0] period_r;
  reg [15:0] match0_r;
  reg wake_permit_r;
  reg unlock_r;
  reg run_applied_r;
  reg [4:0] ps_r;
  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;

  wire setup = psel & ~penable;
  wire wr_go = psel & penable & pwrite;
  wire hit_ctrl1 = paddr == lpw_addr(`LPW_IDX_CTRL1);
  wire hit_gate = paddr == lpw_addr(`LPW_IDX_GATE);
  wire hit_run = paddr == lpw_addr(`LPW_IDX_RUN);
  wire hit_period = paddr == lpw_addr(`LPW_IDX_PERIOD);
  wire hit_match0 = paddr == lpw_addr(`LPW_IDX_MATCH0);
  wire hit_wake = paddr == lpw_addr(`LPW_IDX_WAKE);
  wire hit_protect = paddr == lpw_addr(`LPW_IDX_PROTECT);
  wire hit_count = paddr == lpw_addr(`LPW_IDX_COUNT);
  wire hit_any = hit_ctrl1 | hit_gate | hit_run | hit_period |
    hit_match0 | hit_wake | hit_protect | hit_count;
  // Protected writes are dropped silently, with no error
  wire wr_ok = wr_go & unlock_r;

  // Zero wait states on every access
  assign pready = 1'b1;

  // ****************************************************************
  // Source clock sampling
  // ****************************************************************
  wire [1:0] src_in = {wdt_osc_clock, sub_clock};
  wire [1:0] src_rise;

  // Each pin passes three flops; a level counts once the last two agree
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_src
      reg [`LPW_SYNC_STAGES-1:0] sync_r;
      reg level_r;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_r <= 3'b000;
        end else begin
          sync_r <= {sync_r[1:0], src_in[g]};
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level_r <= 1'b0;
        end else if (sync_r[1] == sync_r[2]) begin
          level_r <= sync_r[2];
        end
      end
      assign src_rise[g] = sync_r[1] & sync_r[2] & ~level_r;
    end
  endgenerate

  // Watchdog oscillator halts in standby unless its stop option is off
  wire wdt_alive = ~(standby_mode & sleep_count_stop_option);
  wire src_tick_raw = ctrl1_r[`LPW_CKSEL_BIT] ?
    (src_rise[1] & wdt_alive) : src_rise[0];
  wire src_tick = src_tick_raw & ~gate_stop_r;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Unlock stays writable so software can always reopen access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_r <= 1'b0;
    end else if (wr_go & hit_protect) begin
      unlock_r <= pwdata[`LPW_UNLOCK_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_r <= `LPW_CTRL1_RST;
    end else if (wr_ok & hit_ctrl1) begin
      ctrl1_r <= pwdata[7:0] & `LPW_CTRL1_MASK;
    end
  end

  // Gate resets stopped so no tick reaches the counter before setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_stop_r <= `LPW_GATE_RST;
    end else if (wr_ok & hit_gate) begin
      gate_stop_r <= pwdata[`LPW_GATE_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
    end else if (wr_ok & hit_run) begin
      run_r <= pwdata[`LPW_RUN_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_r <= `LPW_PERIOD_RST;
    end else if (wr_ok & hit_period) begin
      period_r <= pwdata[15:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match0_r <= `LPW_MATCH0_RST;
    end else if (wr_ok & hit_match0) begin
      match0_r <= pwdata[15:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_permit_r <= 1'b0;
    end else if (wr_ok & hit_wake) begin
      wake_permit_r <= pwdata[`LPW_WKUP_BIT];
    end
  end

  // ****************************************************************
  // Clear request and run control, applied on source ticks
  // ****************************************************************
  wire clr_set = wr_ok & hit_run & pwdata[`LPW_CLR_BIT];

  // A new request wins over the tick that would retire the old one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_req_r <= 1'b0;
    end else if (clr_set) begin
      clr_req_r <= 1'b1;
    end else if (src_tick) begin
      clr_req_r <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_applied_r <= 1'b0;
    end else if (src_tick) begin
      run_applied_r <= run_r;
    end
  end

  // ****************************************************************
  // Prescaler and counter
  // ****************************************************************
  wire [4:0] ps_last = lpw_div_last(ctrl1_r[`LPW_PS_MSB:`LPW_PS_LSB]);
  wire counting = src_tick & run_applied_r & ~clr_req_r;
  wire cnt_en = counting & (ps_r == ps_last);

  // A zero period is prohibited; the counter then stays at zero
  always @* begin
    if (cnt_r == period_r) begin
      cnt_nxt = 16'h0000;
    end else begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_r <= 5'h00;
    end else if (src_tick & clr_req_r) begin
      ps_r <= 5'h00;
    end else if (counting) begin
      if (ps_r >= ps_last) begin
        ps_r <= 5'h00;
      end else begin
        ps_r <= ps_r + 5'h01;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
    end else if (src_tick & clr_req_r) begin
      cnt_r <= 16'h0000;
    end else if (cnt_en) begin
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************************************
  // Compare match 0 and wakeup
  // ****************************************************************
  // One-cycle registered pulses so the event link sees clean levels
  wire match_hit = cnt_en & (cnt_nxt == match0_r) &
    ctrl1_r[`LPW_MRE0_BIT] & standby_mode;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_timer_event <= 1'b0;
    end else begin
      low_power_timer_event <= match_hit;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match0_irq <= 1'b0;
    end else begin
      match0_irq <= match_hit;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_request <= 1'b0;
    end else begin
      wakeup_request <= match_hit & wake_permit_r;
    end
  end

  // ****************************************************************
  // Read data and error
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~hit_any;
    end
  end

  // Captured in the setup cycle, it stands through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= 32'h00000000;
      if (!pwrite) begin
        if (hit_ctrl1) begin
          prdata <= {24'h000000, ctrl1_r};
        end
        if (hit_gate) begin
          prdata <= {31'h00000000, gate_stop_r};
        end
        if (hit_run) begin
          prdata <= {30'h00000000, clr_req_r, run_r};
        end
        if (hit_period) begin
          prdata <= {16'h0000, period_r};
        end
        if (hit_match0) begin
          prdata <= {16'h0000, match0_r};
        end
        if (hit_wake) begin
          prdata <= {31'h00000000, wake_permit_r};
        end
        if (hit_protect) begin
          prdata <= {29'h00000000, unlock_r, 2'b00};
        end
        if (hit_count) begin
          prdata <= {16'h0000, cnt_r};
        end
      end
    end
  end

endmodule // lpw_timer

// >>> tb/lpt_timer_asserts.sv
// Port checker for the low-power timer
`timescale 1ns/10ps
module lpw_timer_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire standby_mode,
  input wire low_power_timer_event,
  input wire match0_irq,
  input wire wakeup_request
);
  localparam C1 = 32'h002002C0;
  localparam GT = 32'h002002C4;
  localparam RN = 32'h002002C8;
  localparam CT = 32'h002002F8;
  wire rd = psel && penable && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence quiet7;
    !low_power_timer_event [*7];
  endsequence
  evt_stby_a:
    assert property (low_power_timer_event |-> $past(standby_mode))
    else $error("event outside standby");
  irq_same_a:
    assert property (match0_irq == low_power_timer_event)
    else $error("irq differs from event");
  wake_evt_a:
    assert property (wakeup_request |-> low_power_timer_event)
    else $error("wakeup without event");
  evt_gap_a:
    assert property ($rose(low_power_timer_event) |=> quiet7)
    else $error("events too close");
  ctrl_resv_a:
    assert property (rd && paddr == C1 |-> prdata[31:8] == 24'h0
      && !prdata[7] && !prdata[5] && !prdata[3])
    else $error("reserved control bits set");
  gate_bits_a:
    assert property (rd && paddr == GT |-> prdata[31:1] == 31'h0)
    else $error("gate readback too wide");
  run_bits_a:
    assert property (rd && paddr == RN |-> prdata[31:2] == 30'h0)
    else $error("run readback too wide");
  count_width_a:
    assert property (rd && paddr == CT |-> prdata[31:16] == 16'h0)
    else $error("count wider than 16 bits");
endmodule // lpw_timer_asserts
bind lpw_timer lpw_timer_asserts lpw_timer_asserts_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .standby_mode,
  .low_power_timer_event, .match0_irq, .wakeup_request);

// >>> tb/lpt_timer_test.sv
// Self-checking bench for the low-power timer
`timescale 1ns/10ps
module low_power_wakeup_timer_test;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [31:0] paddr = 0, pwdata = 0, r;
  reg sub_clock = 0, wdt_osc_clock = 0, standby_mode = 0, sc_stop = 0;
  reg [4:0] div = 0;
  reg e;
  wire [31:0] prdata;
  wire pready, pslverr, evt, irq, wake;
  integer miscompares = 0, checked = 0, n, c, t;
  localparam C1 = 32'h002002C0, GT = 32'h002002C4, RN = 32'h002002C8;
  localparam PD = 32'h002002D0, M0 = 32'h002002E0, WK = 32'h002002E8;
  localparam PR = 32'h002002F0, CT = 32'h002002F8;
  lpw_timer lpw_timer_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sub_clock,
    .wdt_osc_clock, .standby_mode, .sleep_count_stop_option(sc_stop),
    .low_power_timer_event(evt), .match0_irq(irq), .wakeup_request(wake));
  always #4 pclk = ~pclk;
  // Source clocks at pclk/16 and pclk/8
  always @(posedge pclk) begin
    div <= div + 5'h1;
    sub_clock <= div[3];
    wdt_osc_clock <= div[2];
  end
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task apb(input [31:0] a, input w, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
        k = k + 1;
        @(posedge pclk);
      end
      if (k >= 50) begin
        miscompares = miscompares + 1;
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task rd(input [31:0] a, input [31:0] x);
    begin
      apb(a, 0, 0);
      cmp(r, x);
    end
  endtask
  // Counts cycles until an event, up to lim
  task wev(input integer lim);
    begin
      n = 0;
      @(posedge pclk);
      while (evt !== 1'b1 && n < lim) begin
        n = n + 1;
        @(posedge pclk);
      end
    end
  endtask
  task stop_test;
    begin
      if (miscompares == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #400000;
    miscompares = miscompares + 1;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd(C1, 32'h01);
    apb(C1, 1, 32'h51);
    rd(C1, 32'h01);
    apb(PR, 1, 32'h4);
    apb(C1, 1, 32'h55);
    rd(C1, 32'h55);
    apb(32'h002002FC, 1, 32'h1);
    cmp(e, 32'h1);
    apb(C1, 1, 32'h41);
    apb(PD, 1, 32'h3);
    apb(M0, 1, 32'h2);
    apb(WK, 1, 32'h1);
    apb(GT, 1, 32'h0);
    apb(RN, 1, 32'h2);
    t = 0;
    apb(RN, 0, 0);
    while (r[1] && t < 20) begin
      apb(RN, 0, 0);
      t = t + 1;
    end
    cmp(r, 32'h0);
    rd(CT, 32'h0);
    apb(RN, 1, 32'h1);
    wev(300);
    cmp(n, 300);
    standby_mode <= 1;
    wev(300);
    cmp(wake, 32'h1);
    cmp(irq, 32'h1);
    wev(300);
    cmp(n + 1, 128);
    repeat (6) begin
      apb(CT, 0, 0);
      cmp(r < 4, 32'h1);
    end
    apb(RN, 1, 32'h0);
    apb(C1, 1, 32'h01);
    apb(RN, 1, 32'h1);
    wev(300);
    cmp(n, 300);
    for (c = 1; c < 6; c = c + 1) begin
      apb(RN, 1, 32'h0);
      apb(GT, 1, 32'h1);
      apb(C1, 1, 32'h50 | c);
      apb(GT, 1, 32'h0);
      apb(RN, 1, 32'h1);
      wev(3000);
      wev(3000);
      cmp(n + 1, 32 << c);
    end
    sc_stop <= 1;
    wev(3000);
    cmp(n, 3000);
    sc_stop <= 0;
    wev(3000);
    wev(3000);
    cmp(n + 1, 1024);
    stop_test;
  end
endmodule // low_power_wakeup_timer_test
